// >>> logic/lds_pkg.sv
// Constants for the lane deskew block: frame layout, lane geometry,
// register map, control fields, reset values and sync states.
// Assumes one system clock and a much slower link clock.
package lds_pkg;
    // ==========================================================
    // Lane and frame geometry
    localparam int           NCH       = 4;
    localparam int           NLN       = 16;
    localparam int           HIST_W    = 16;
    localparam int           SKEW_W    = 8;
    localparam int           REF_W     = SKEW_W + 64;
    // Framing F6 F6 28 28, then four idle expansion bytes
    localparam logic [63:0]  FRAME_HDR = 64'hf6f62828aaaaaaaa;
    localparam logic [8:0]   HDR_BITS  = 9'h040;
    localparam logic [8:0]   LAST_POS  = 9'h13f;
    localparam logic [5:0]   SMP_LAST  = 6'h3f;
    localparam logic [3:0]   TAP_CTR   = 4'h8;
    localparam logic [15:0]  TAP_RST   = 16'h8888;
    localparam logic [2:0]   FIFO_D    = 3'h4;
    localparam logic [15:0]  ERR_MAX   = 16'hffff;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]   A_CTRL    = 8'h00;
    localparam logic [7:0]   A_STAT    = 8'h04;
    localparam logic [7:0]   A_ERR01   = 8'h08;
    localparam logic [7:0]   A_ERR23   = 8'h0c;
    localparam logic [7:0]   A_TAPLO   = 8'h10;
    localparam logic [7:0]   A_TAPHI   = 8'h14;
    localparam int           CTRL_MODE = 4;
    localparam int           CTRL_CLR  = 5;
    localparam logic [4:0]   CTRL_RST  = 5'h0f;

    // ==========================================================
    // Reference-lane sync states
    typedef enum logic [0:0] {
        LDS_HUNT  = 1'b0,
        LDS_TRACK = 1'b1
    } lds_sync_e;
endpackage : lds_pkg

// >>> logic/lds_top.sv
// Lane deskew block: striping source with reference-frame builder,
// and a sink that deskews lanes, raises alarms and counts errors.
// Assumes a free-running link clock slower than CLK_I / 4 whose
// far end launches data away from the rising edge.
//
// Function
// RULE1: Core bits go round-robin over a channel's four lanes, one each.
// RULE2: First bit of each round goes to lane 3, last to lane 0.
// RULE3: Serdes mode puts fiber one's first bit on lane 15, last 12.
// RULE4: Every lane passes a retiming FIFO between core and link rates.
// RULE5: Each reference frame starts F6, F6, then 28, 28.
// RULE6: Four expansion header bytes 1010 1010 follow the framing.
// RULE7: Each lane is then copied for 64 bit times, one sample.
// RULE8: Channel one samples lane 3 first and lane 0 last.
// RULE9: Channels two to four sample 7..4, 11..8, 15..12.
// RULE10: After the last sample a new frame starts at once, forever.
// RULE11: Lanes 3, 7, 11, 15 lead fibers one to four.
// RULE12: Sink finds framing and header to locate the samples.
// RULE13: Each sample is matched to its lane, giving the lane delay.
// RULE14: Each lane gets its own adjustable delay.
// RULE15: Transmit alarm set when any lane misses its sample.
// RULE16: Transmit alarm clears once all four channels are locked.
// RULE17: Skew is watched always; alarm stays clear while consistent.
// RULE18: Channels keep deskewing while other channels are down.
// RULE19: Receive alarm holds until all four lanes match stably.
// RULE20: Each receive channel has its own alarm.
// RULE21: Mismatches count as link errors, readable for testing.
// RULE22: Channels two to four build frames from their own lanes.
// RULE23: Samples line up with the frame so bit nine follows order.
// RULE24: Lane delay moves one bit time per sample.
// RULE25: Expansion header never carries the framing values.
// RULE26: Alarms start set after reset until first lock.

`timescale 1ns/10ps
`default_nettype none

module lds_top (
    input  wire logic                      CLK_I,
    input  wire logic                      RST_N_I,
    input  wire logic                      CYC_I,
    input  wire logic                      STB_I,
    input  wire logic                      WE_I,
    input  wire logic [7:0]                ADR_I,
    input  wire logic [3:0]                SEL_I,
    input  wire logic [31:0]               DAT_I,
    output logic      [31:0]               DAT_O,
    output logic                           ACK_O,
    input  wire logic                      LINK_CLK_I,
    input  wire logic [lds_pkg::NCH-1:0]   CORE_BIT_I,
    input  wire logic [lds_pkg::NCH-1:0]   CORE_VALID_I,
    output logic      [lds_pkg::NCH-1:0]   CORE_READY_O,
    output logic      [lds_pkg::NLN-1:0]   TX_DATA_LANES_O,
    output logic      [lds_pkg::NCH-1:0]   TX_REFERENCE_LANE_O,
    input  wire logic [lds_pkg::NLN-1:0]   RX_DATA_LANES_I,
    input  wire logic [lds_pkg::NCH-1:0]   RX_REFERENCE_LANE_I,
    output logic      [lds_pkg::NLN-1:0]   DESKEW_O,
    output logic      [lds_pkg::NCH-1:0]   FIBER_O,
    output logic      [lds_pkg::NCH-1:0]   RX_ALIGN_LOSS_ALARM_O,
    output logic                           TX_ALIGN_LOSS_ALARM_O
);
    import lds_pkg::*;

    // ==========================================================
    // Link clock sampling and bit-time tick
    logic [2:0]           lclk_reg, lclk_next;
    logic                 tick;
    logic [NCH+NLN-1:0]   rx_s1_reg, rx_s2_reg;

    always_comb begin
        lclk_next = {lclk_reg[1:0], LINK_CLK_I};
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lclk_reg  <= 3'h0;
            rx_s1_reg <= 20'h0;
            rx_s2_reg <= 20'h0;
        end else begin
            lclk_reg  <= lclk_next;
            rx_s1_reg <= {RX_REFERENCE_LANE_I, RX_DATA_LANES_I};
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // Rising edge seen on the second and third stages only
    assign tick = lclk_reg[1] & ~lclk_reg[2];

    // ==========================================================
    // Wishbone slave
    logic        ack_reg, ack_next;
    logic [4:0]  ctrl_reg, ctrl_next;
    logic [31:0] dat_reg, dat_next;
    logic [31:0] rd_word;
    logic        err_clr;
    logic        tx_alarm_reg, tx_alarm_next;
    logic [NCH-1:0]   alarm_all, lock_all;
    logic [4*NCH*4-1:0] err_all;
    logic [4*NLN-1:0] taps_all;

    always_comb begin
        case (ADR_I)
            A_CTRL:  rd_word = {27'h0, ctrl_reg};
            A_STAT:  rd_word = {20'h0, lock_all, 3'h0, tx_alarm_reg,
                                alarm_all};
            A_ERR01: rd_word = err_all[31:0];
            A_ERR23: rd_word = err_all[63:32];
            A_TAPLO: rd_word = taps_all[31:0];
            A_TAPHI: rd_word = taps_all[63:32];
            default: rd_word = 32'h0;
        endcase
    end

    always_comb begin
        ack_next  = CYC_I & STB_I & ~ack_reg;
        ctrl_next = ctrl_reg;
        dat_next  = dat_reg;
        err_clr   = 1'b0;
        if (ack_next) begin
            dat_next = rd_word;
            if (WE_I && ADR_I == A_CTRL && SEL_I[0]) begin
                ctrl_next = DAT_I[4:0];
                err_clr   = DAT_I[CTRL_CLR];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_reg  <= 1'b0;
            ctrl_reg <= CTRL_RST;
            dat_reg  <= 32'h0;
        end else begin
            ack_reg  <= ack_next;
            ctrl_reg <= ctrl_next;
            dat_reg  <= dat_next;
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = dat_reg;

    // ==========================================================
    // Transmit source: striping and per-channel retiming FIFO
    logic [NLN-1:0] nib_out;

    for (genvar c = 0; c < NCH; c++) begin : g_src
        logic [3:0] mem_reg [FIFO_D];
        logic [3:0] mem_next [FIFO_D];
        logic [2:0] col_reg, col_next;
        logic [1:0] bcnt_reg, bcnt_next;
        logic [1:0] wp_reg, wp_next, rp_reg, rp_next;
        logic [2:0] occ_reg, occ_next;
        logic       push, pop, take;

        assign CORE_READY_O[c] = occ_reg != FIFO_D;
        assign take = CORE_VALID_I[c] & CORE_READY_O[c];

        always_comb begin
            mem_next  = mem_reg;
            col_next  = col_reg;
            bcnt_next = bcnt_reg;
            wp_next   = wp_reg;
            rp_next   = rp_reg;
            push      = 1'b0;
            pop       = tick && occ_reg != 3'h0;
            if (take) begin
                bcnt_next = bcnt_reg + 2'h1;                // RULE1
                col_next  = {col_reg[1:0], CORE_BIT_I[c]};
                if (bcnt_reg == 2'h3) begin
                    // Oldest bit lands in lane 3, newest in lane 0
                    push             = 1'b1;
                    mem_next[wp_reg] = {col_reg, CORE_BIT_I[c]}; // RULE2
                    wp_next          = wp_reg + 2'h1;
                end
            end
            if (pop) begin
                rp_next = rp_reg + 2'h1;                    // RULE4
            end
            occ_next = occ_reg + {2'h0, push} - {2'h0, pop};
        end

        // Underrun sends zeros rather than stalling the frame
        assign nib_out[4*c +: 4] = pop ? mem_reg[rp_reg] : 4'h0;

        always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                for (int i = 0; i < FIFO_D; i++) begin
                    mem_reg[i] <= 4'h0;
                end
                col_reg  <= 3'h0;
                bcnt_reg <= 2'h0;
                wp_reg   <= 2'h0;
                rp_reg   <= 2'h0;
                occ_reg  <= 3'h0;
            end else begin
                mem_reg  <= mem_next;
                col_reg  <= col_next;
                bcnt_reg <= bcnt_next;
                wp_reg   <= wp_next;
                rp_reg   <= rp_next;
                occ_reg  <= occ_next;
            end
        end
    end

    // ==========================================================
    // Transmit source: lane output and reference-frame builder
    logic [NLN-1:0] tx_reg, tx_next;
    logic [NCH-1:0] txref_reg, txref_next;
    logic [8:0]     fpos_reg, fpos_next;
    logic [8:0]     smp;
    logic [3:0]     nib_g;

    always_comb begin
        tx_next    = tx_reg;
        txref_next = txref_reg;
        fpos_next  = fpos_reg;
        smp        = fpos_reg - HDR_BITS;
        nib_g      = 4'h0;
        if (tick) begin
            for (int g = 0; g < NCH; g++) begin
                if (ctrl_reg[CTRL_MODE]) begin
                    tx_next[4*g +: 4] = nib_out[4*(3-g) +: 4]; // RULE3
                end else begin
                    tx_next[4*g +: 4] = nib_out[4*g +: 4];
                end
                nib_g = tx_next[4*g +: 4];
                if (fpos_reg < HDR_BITS) begin
                    // RULE5 RULE6 RULE25
                    txref_next[g] = FRAME_HDR[SMP_LAST - fpos_reg[5:0]];
                end else begin
                    // RULE7 RULE8 RULE9 RULE22 RULE23
                    txref_next[g] = nib_g[2'h3 - smp[7:6]];
                end
            end
            fpos_next = (fpos_reg == LAST_POS) ? 9'h0
                                               : fpos_reg + 9'h1; // RULE10
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_reg    <= 16'h0;
            txref_reg <= 4'h0;
            fpos_reg  <= 9'h0;
        end else begin
            tx_reg    <= tx_next;
            txref_reg <= txref_next;
            fpos_reg  <= fpos_next;
        end
    end

    assign TX_DATA_LANES_O     = tx_reg;
    assign TX_REFERENCE_LANE_O = txref_reg;

    // ==========================================================
    // Sink: lane history and adjustable delay
    logic [NLN-1:0][HIST_W-1:0] hist_reg, hist_next;
    logic [NLN-1:0]             desk_reg, desk_next;
    logic [NCH-1:0]             fib_reg, fib_next;

    for (genvar l = 0; l < NLN; l++) begin : g_lane
        assign hist_next[l] = tick ? {hist_reg[l][HIST_W-2:0], rx_s2_reg[l]}
                                   : hist_reg[l];
        assign desk_next[l] = tick ? hist_reg[l][taps_all[4*l +: 4]]
                                   : desk_reg[l];             // RULE14
    end

    for (genvar g = 0; g < NCH; g++) begin : g_fib
        assign fib_next[g] = desk_next[4*g+3];               // RULE11
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hist_reg <= '0;
            desk_reg <= 16'h0;
            fib_reg  <= 4'h0;
        end else begin
            hist_reg <= hist_next;
            desk_reg <= desk_next;
            fib_reg  <= fib_next;
        end
    end

    assign DESKEW_O = desk_reg;
    assign FIBER_O  = fib_reg;

    function automatic logic [3:0] lds_first(input logic [HIST_W-1:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = HIST_W - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : lds_first

    // ==========================================================
    // Sink: per-channel deskew controller
    // A false header inside sample data is ignored while tracking,
    // since a new header is only accepted at the expected position.
    for (genvar c = 0; c < NCH; c++) begin : g_sink
        lds_sync_e         st_reg, st_next;
        logic [8:0]        pos_reg, pos_next;
        logic [HIST_W-1:0] mask_reg, mask_next, m;
        logic [3:0]        ok_reg, ok_next;
        logic [15:0]       tap_reg, tap_next;
        logic              alarm_reg, alarm_next;
        logic [15:0]       err_reg, err_next;
        logic [REF_W-1:0]  ref_reg, ref_next;
        logic [1:0]        k;
        logic [3:0]        tap, first;
        logic              hit, miss, evt;

        always_comb begin
            st_next    = st_reg;
            pos_next   = pos_reg;
            mask_next  = mask_reg;
            ok_next    = ok_reg;
            tap_next   = tap_reg;
            alarm_next = alarm_reg;
            err_next   = err_reg;
            ref_next   = ref_reg;
            evt        = 1'b0;
            k     = 2'h3 - pos_reg[7:6];                      // RULE8 RULE9
            tap   = tap_reg[4*k +: 4];
            hit   = ref_reg[REF_W-1:SKEW_W] == FRAME_HDR;     // RULE12
            m     = ((pos_reg[5:0] == 6'h0) ? {HIST_W{1'b1}} : mask_reg)
                  & ~(hist_reg[4*c+k] ^ {HIST_W{ref_reg[SKEW_W]}}); // RULE13
            first = lds_first(m);
            miss  = hist_reg[4*c+k][tap] != ref_reg[SKEW_W];
            if (tick) begin
                ref_next = {ref_reg[REF_W-2:0], rx_s2_reg[NLN+c]};
                if (!ctrl_reg[c]) begin
                    // Disabled channel idles alone; others go on
                    st_next    = LDS_HUNT;                    // RULE18
                    ok_next    = 4'h0;
                    alarm_next = 1'b1;
                end else begin
                    case (st_reg)
                        LDS_HUNT: begin
                            if (hit) begin
                                st_next  = LDS_TRACK;
                                pos_next = 9'h0;
                            end
                        end
                        LDS_TRACK: begin
                            pos_next = pos_reg + 9'h1;
                            if (pos_reg == LAST_POS) begin
                                pos_next = 9'h0;
                                if (!hit) begin
                                    st_next    = LDS_HUNT;
                                    ok_next    = 4'h0;
                                    alarm_next = 1'b1;
                                end
                            end else if (!pos_reg[8]) begin
                                mask_next = m;
                                evt       = miss;             // RULE21
                                if (pos_reg[5:0] == SMP_LAST) begin
                                    ok_next[k] = m[tap];      // RULE17
                                    if (m != 16'h0 && !m[tap]) begin
                                        tap_next[4*k +: 4] = (first > tap)
                                            ? tap + 4'h1
                                            : tap - 4'h1;     // RULE24
                                    end
                                    if (!m[tap]) begin
                                        alarm_next = 1'b1;    // RULE15
                                    end else if (&ok_next) begin
                                        alarm_next = 1'b0;    // RULE19
                                    end
                                end
                            end
                        end
                        default: st_next = LDS_HUNT;
                    endcase
                end
            end
            // A mismatch in the clearing cycle still counts once
            if (err_clr) begin
                err_next = {15'h0, evt};
            end else if (evt && err_reg != ERR_MAX) begin
                err_next = err_reg + 16'h1;
            end
        end

        always_ff @(posedge CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                st_reg    <= LDS_HUNT;
                pos_reg   <= 9'h0;
                mask_reg  <= 16'h0;
                ok_reg    <= 4'h0;
                tap_reg   <= TAP_RST;
                alarm_reg <= 1'b1;                            // RULE26
                err_reg   <= 16'h0;
                ref_reg   <= '0;
            end else begin
                st_reg    <= st_next;
                pos_reg   <= pos_next;
                mask_reg  <= mask_next;
                ok_reg    <= ok_next;
                tap_reg   <= tap_next;
                alarm_reg <= alarm_next;
                err_reg   <= err_next;
                ref_reg   <= ref_next;
            end
        end

        assign alarm_all[c]          = alarm_reg;             // RULE20
        assign lock_all[c]           = &ok_reg;
        assign err_all[16*c +: 16]   = err_reg;
        assign taps_all[16*c +: 16]  = tap_reg;
    end

    // ==========================================================
    // Overall alarm over enabled channels
    always_comb begin
        tx_alarm_next = (ctrl_reg[3:0] == 4'h0)
                      | (|(alarm_all & ctrl_reg[3:0]));       // RULE15 RULE16
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_alarm_reg <= 1'b1;                             // RULE26
        end else begin
            tx_alarm_reg <= tx_alarm_next;
        end
    end

    assign RX_ALIGN_LOSS_ALARM_O = alarm_all;
    assign TX_ALIGN_LOSS_ALARM_O = tx_alarm_reg;

endmodule : lds_top

`default_nettype wire

// >>> verif/lds_far.sv
// Far-side model: loops the transmit lanes back onto the receive lanes.
// Assumes a free-running link clock; it launches on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module lds_far (
    input  wire logic        link_clk_i,
    input  wire logic        flip_i,
    input  wire logic [15:0] tx_lanes_i,
    input  wire logic [3:0]  tx_ref_i,
    output logic      [15:0] rx_lanes_o,
    output logic      [3:0]  rx_ref_o
);
    logic [1:0] late_reg;
    initial begin
        rx_lanes_o = '0;
        rx_ref_o = '0;
        late_reg = '0;
    end
    // ====================
    // Launch mid-bit so the sink never samples a changing line
    always @(negedge link_clk_i) begin
        late_reg <= {late_reg[0], tx_lanes_i[5]};
        rx_lanes_o <= {tx_lanes_i[15:6], late_reg[1],
                       tx_lanes_i[4] ^ flip_i, tx_lanes_i[3:0]};
        rx_ref_o <= tx_ref_i;
    end
endmodule : lds_far
`default_nettype wire

// >>> verif/lds_chk.sv
// Checker for the lane deskew block: bus handshake, lane timing, alarms.
// Assumes it is bound to the block's top module.
`timescale 1ns/10ps
`default_nettype none
module lds_chk (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        ACK_O,
    input wire logic [15:0] TX_DATA_LANES_O,
    input wire logic [3:0]  TX_REFERENCE_LANE_O,
    input wire logic [15:0] DESKEW_O,
    input wire logic [3:0]  FIBER_O,
    input wire logic [3:0]  RX_ALIGN_LOSS_ALARM_O,
    input wire logic        TX_ALIGN_LOSS_ALARM_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ====================
    // Bus handshake
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    // ====================
    // Lanes move only on link bit times, at least six system cycles apart
    a_lane_steady: assert property ($changed(TX_DATA_LANES_O) |=>
        $stable(TX_DATA_LANES_O)[*5]) else $error("lanes moved off tick");
    a_ref_steady: assert property ($changed(TX_REFERENCE_LANE_O) |=>
        $stable(TX_REFERENCE_LANE_O)[*5]) else $error("ref moved off tick");
    a_fiber_map: assert property ($stable(DESKEW_O)[*3] |->
        FIBER_O == {DESKEW_O[15], DESKEW_O[11], DESKEW_O[7], DESKEW_O[3]})
        else $error("fiber not led by lane 3 of group");
    // ====================
    // Alarms
    a_reset_alarm: assert property ($rose(RST_N_I) |->
        (RX_ALIGN_LOSS_ALARM_O == 4'hf && TX_ALIGN_LOSS_ALARM_O)[*8])
        else $error("alarm clear right after reset");
    a_rx_alarm_tick: assert property ($changed(RX_ALIGN_LOSS_ALARM_O) |=>
        $stable(RX_ALIGN_LOSS_ALARM_O)[*5]) else $error("alarm moved off tick");
    a_tx_alarm_lock: assert property ($fell(TX_ALIGN_LOSS_ALARM_O) |->
        RX_ALIGN_LOSS_ALARM_O != 4'hf ||
        $past(RX_ALIGN_LOSS_ALARM_O) != 4'hf)
        else $error("tx alarm cleared with no channel locked");
endmodule : lds_chk

bind lds_top lds_chk u_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .ACK_O(ACK_O), .TX_DATA_LANES_O(TX_DATA_LANES_O),
    .TX_REFERENCE_LANE_O(TX_REFERENCE_LANE_O), .DESKEW_O(DESKEW_O),
    .FIBER_O(FIBER_O), .RX_ALIGN_LOSS_ALARM_O(RX_ALIGN_LOSS_ALARM_O),
    .TX_ALIGN_LOSS_ALARM_O(TX_ALIGN_LOSS_ALARM_O)
);
`default_nettype wire

// >>> verif/lds_top_bench.sv
// Self-checking bench for the lane deskew block, lanes looped back.
// Assumes the far-side model adds two bit times of skew on lane 5.
`timescale 1ns/10ps
`default_nettype none
module lds_top_bench;
    import lds_pkg::*;
    logic        clk, rst_n, cyc, stb, we, ack, lclk, flip, feed, tx_alarm;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd;
    logic [3:0]  cbit, cval, crdy, tref, rref, rx_alarm, fiber;
    logic [15:0] tlan, rlan, desk, lfsr;
    logic [63:0] hist [4];
    logic [159:0] tq;
    int          fail_count, total_checks, pos, frames, mon_bad, hdr;

    lds_top u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .LINK_CLK_I(lclk), .CORE_BIT_I(cbit),
        .CORE_VALID_I(cval), .CORE_READY_O(crdy), .TX_DATA_LANES_O(tlan),
        .TX_REFERENCE_LANE_O(tref), .RX_DATA_LANES_I(rlan),
        .RX_REFERENCE_LANE_I(rref), .DESKEW_O(desk), .FIBER_O(fiber),
        .RX_ALIGN_LOSS_ALARM_O(rx_alarm), .TX_ALIGN_LOSS_ALARM_O(tx_alarm));
    lds_far u_far (.link_clk_i(lclk), .flip_i(flip), .tx_lanes_i(tlan),
        .tx_ref_i(tref), .rx_lanes_o(rlan), .rx_ref_o(rref));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // Offset keeps the link clock out of phase with the system clock
    initial begin
        lclk = 0;
        #1230;
        forever #400 lclk = ~lclk;
    end
    // ====================
    // Shared tasks
    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        if (n >= 50) chk(0, 1, "bus timeout");
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : bus
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // ====================
    // Core feed, pseudo-random so every tap gives a distinct sample
    always @(posedge clk) begin
        if (feed) begin
            cval <= 4'hf;
            cbit <= lfsr[3:0];
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end
    // Frame monitor: TX lanes are settled at the link falling edge
    always @(negedge lclk) begin
        // Deskewed lanes trail the sent lanes by ten bit times when locked
        if (!flip && rx_alarm === 4'h0 && desk !== tq[159:144])
            mon_bad++;
        tq = {tq[143:0], tlan};
        hdr = 0;
        for (int g = 0; g < 4; g++) begin
            hist[g] = {hist[g][62:0], tref[g]};
            hdr += int'(hist[g] === FRAME_HDR);
            if (pos >= 64 && pos < 320 &&
                tref[g] !== tlan[4 * g + 3 - (pos - 64) / 64]) mon_bad++;
        end
        if (hdr == 4 && frames > 0) chk(pos, 383, "frame length");
        if (hdr == 4) frames++;
        pos = (hdr == 4) ? 64 : pos + 1;
    end
    // ====================
    // Main sequence
    initial begin
        int n;
        {cyc, stb, we, flip, feed, adr, wdat} = '0;
        {cbit, cval, lfsr} = {8'h00, 16'hace1};
        {fail_count, total_checks, frames, mon_bad, pos} = {128'h0, 32'd1000};
        rst_n = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk(rx_alarm, 4'hf, "rx alarms after reset");
        chk(tx_alarm, 1, "tx alarm after reset");
        chk(crdy, 4'hf, "ready after reset");
        bus(0, A_CTRL, 0); chk(rd, 32'h0f, "ctrl reset");
        bus(0, A_TAPLO, 0); chk(rd, 32'h88888888, "tap reset");
        bus(0, 8'h40, 0); chk(rd, 0, "unmapped read");
        $display("test reset done");
        // Plain mode leads group 0, serdes mode moves channel 0 to group 3
        for (int md = 0; md < 2; md++) begin
            bus(1, A_CTRL, 32'h0f | (md << 4));
            for (int i = 3; i >= 0; i--) begin
                @(posedge clk);
                cval[0] <= 1'b1;
                cbit[0] <= 4'b1011 >> i;
            end
            @(posedge clk);
            cval[0] <= 1'b0;
            for (n = 0; tlan[12*md +: 4] === 4'h0 && n < 100; n++)
                @(posedge clk);
            chk(tlan[12*md +: 4], 4'hb, "first bit");
        end
        bus(1, A_CTRL, 32'h0f);
        $display("test striping done");
        feed <= 1'b1;
        for (n = 0; rx_alarm !== 4'h0 && n < 30000; n++) @(posedge clk);
        // The overall alarm is registered one cycle behind the channels
        @(posedge clk);
        chk(rx_alarm, 0, "rx alarms after lock");
        chk(tx_alarm, 0, "tx alarm after lock");
        bus(0, A_TAPLO, 0); chk(rd, 32'h88688888, "lane 5 delay");
        repeat (3000) @(posedge clk);
        chk(rx_alarm, 0, "alarms stay clear");
        bus(1, A_CTRL, 32'h2f);
        bus(0, A_ERR01, 0); chk(rd, 0, "no errors when locked");
        $display("test lock done");
        flip <= 1'b1;
        repeat (4000) @(posedge clk);
        chk(rx_alarm, 4'b0010, "only channel 2 lost");
        chk(tx_alarm, 1, "tx alarm on lost lane");
        bus(0, A_ERR01, 0); chk(rd[31:16] != 0, 1, "errors counted");
        chk(mon_bad, 0, "lane samples");
        chk(frames > 2, 1, "frames repeat");
        $display("test fault done");
        print_verdict();
    end
    initial begin
        #(70000 * 100);
        chk(0, 1, "watchdog expired");
        print_verdict();
    end
endmodule : lds_top_bench
`default_nettype wire
